/* File: core/hfa_top.sv */
// HDLC framing and CRC assist: receive unframer, transmit framer, CRC helper.
// Assumes a controller port with one-cycle strobes and read data one cycle later.
`timescale 1ns/100ps
`include "hfa_cfg.svh"

module hfa_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	logic [7:0] rx_bit_count_reg;
	logic [7:0] tx_bit_count_reg;
	logic thr_sel_reg;
	logic frm_rst_reg;
	logic rx_go_reg;
	logic tx_done_reg;
	logic drained_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rx_raw_mem [0:15];
	logic [3:0] rx_wr_ptr_reg;
	logic [7:0] rx_fifo_mem [0:20];
	logic [4:0] rx_head_reg;
	logic [4:0] rx_tail_reg;
	logic [4:0] rx_level_reg;
	logic [7:0] tx_fifo_mem [0:20];
	logic [4:0] tx_head_reg;
	logic [4:0] tx_tail_reg;
	logic [4:0] tx_level_reg;
	logic [7:0] tx_buf_mem [0:15];
	logic [3:0] tx_rd_ptr_reg;
	hfa_pkg::hfa_state_e rx_state_reg;
	hfa_pkg::hfa_state_e tx_state_reg;
	logic [6:0] rx_idx_reg;
	logic [7:0] rx_win_reg;
	logic [3:0] rx_win_cnt_reg;
	logic [2:0] rx_ones_reg;
	logic [7:0] rx_asm_reg;
	logic [2:0] rx_asm_cnt_reg;
	logic [6:0] tx_idx_reg;
	logic [7:0] tx_cur_reg;
	logic [3:0] tx_cur_cnt_reg;
	logic tx_cur_flag_reg;
	logic [2:0] tx_ones_reg;
	logic frst;
	logic wr_rx_bits;
	logic wr_rx_data;
	logic wr_tx_bits;
	logic wr_tx_data;
	logic wr_ctrl;
	logic rd_rx_data;
	logic rd_tx_data;
	logic rx_step;
	logic rx_bit;
	logic [7:0] rx_win_n;
	logic rx_is_flag;
	logic rx_out;
	logic rx_drop;
	logic rx_push;
	logic rx_pop;
	logic rx_last;
	logic [7:0] rx_asm_n;
	logic tx_step;
	logic tx_load;
	logic tx_pop;
	logic tx_stuff;
	logic tx_bit;
	logic tx_last;
	logic tx_flag_sent;
	logic [4:0] tx_thr;
	logic [7:0] ctrl_status;
	logic [7:0] crc_out;
	logic [7:0] crc_status;
	logic [7:0] crc_low;
	logic [7:0] crc_high;

	function automatic logic [4:0] hfa_wrap(input logic [4:0] p);
		return (p == `HFA_FIFO_LAST) ? 5'h00 : p + 5'h01;
	endfunction

	function automatic logic hfa_hit(input logic [15:0] a, input logic [15:0] o);
		return a == o;
	endfunction

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign wr_rx_bits = wr && hfa_hit(addr, `HFA_A_RX_BIT_COUNT);
	assign wr_rx_data = wr && hfa_hit(addr, `HFA_A_RX_DATA);
	assign wr_tx_bits = wr && hfa_hit(addr, `HFA_A_TX_BIT_COUNT);
	assign wr_tx_data = wr && hfa_hit(addr, `HFA_A_TX_DATA);
	assign wr_ctrl = wr && hfa_hit(addr, `HFA_A_CTRL);
	assign rd_rx_data = rd && hfa_hit(addr, `HFA_A_RX_DATA);
	assign rd_tx_data = rd && hfa_hit(addr, `HFA_A_TX_DATA);
	assign frst = !rst_n || frm_rst_reg;

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			thr_sel_reg <= 1'b0;
			frm_rst_reg <= 1'b0;
		end else if (wr_ctrl) begin
			thr_sel_reg <= wdata[`HFA_CS_THR_SEL];
			frm_rst_reg <= wdata[`HFA_CS_RESET];
		end
	end

	always_ff @(posedge clk) begin
		if (frst) begin
			rx_bit_count_reg <= 8'h00;
			tx_bit_count_reg <= 8'h00;
		end else begin
			if (wr_rx_bits) begin
				rx_bit_count_reg <= wdata;
			end
			if (wr_tx_bits) begin
				tx_bit_count_reg <= wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive raw buffer and go flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (frst) begin
			rx_wr_ptr_reg <= 4'h0;
		end else if (wr_rx_data) begin
			rx_raw_mem[rx_wr_ptr_reg] <= wdata;
			rx_wr_ptr_reg <= rx_wr_ptr_reg + 4'h1;
		end else if (rx_last) begin
			rx_wr_ptr_reg <= 4'h0;
		end
	end

	// Software set wins over the hardware clear
	always_ff @(posedge clk) begin
		if (frst) begin
			rx_go_reg <= 1'b0;
		end else if (wr_ctrl && wdata[`HFA_CS_RX_GO]) begin
			rx_go_reg <= 1'b1;
		end else if (rx_last || (rx_state_reg == hfa_pkg::HFA_IDLE && rx_go_reg
			&& rx_bit_count_reg == 8'h00)) begin
			rx_go_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Receive unframer
	// ----------------------------------------------------------------
	always_comb begin
		rx_step = (rx_state_reg == hfa_pkg::HFA_RUN) && (rx_level_reg != `HFA_FIFO_FULL);
		rx_bit = rx_raw_mem[rx_idx_reg[6:3]][rx_idx_reg[2:0]];
		rx_win_n = {rx_bit, rx_win_reg[7:1]};
		rx_is_flag = (rx_win_cnt_reg >= 4'h7) && (rx_win_n == `HFA_FLAG);
		rx_out = (rx_win_cnt_reg == 4'h8);
		rx_drop = (rx_ones_reg == `HFA_STUFF_RUN) && !rx_win_reg[0];
		rx_asm_n = {rx_win_reg[0], rx_asm_reg[7:1]};
		rx_push = rx_step && rx_out && !rx_drop && (rx_asm_cnt_reg == 3'h7);
		rx_last = rx_step && ((rx_idx_reg + 7'h01 == rx_bit_count_reg[6:0]
			&& !rx_bit_count_reg[7]) || rx_idx_reg == `HFA_BUF_LAST_BIT);
	end

	always_ff @(posedge clk) begin
		if (frst) begin
			rx_state_reg <= hfa_pkg::HFA_IDLE;
			rx_idx_reg <= 7'h00;
			rx_win_reg <= 8'h00;
			rx_win_cnt_reg <= 4'h0;
			rx_ones_reg <= 3'h0;
			rx_asm_reg <= 8'h00;
			rx_asm_cnt_reg <= 3'h0;
		end else begin
			case (rx_state_reg)
				hfa_pkg::HFA_IDLE: begin
					rx_idx_reg <= 7'h00;
					if (rx_go_reg && rx_bit_count_reg != 8'h00) begin
						rx_state_reg <= hfa_pkg::HFA_RUN;
					end
				end
				hfa_pkg::HFA_RUN: begin
					if (rx_step) begin
						rx_win_reg <= rx_win_n;
						rx_idx_reg <= rx_idx_reg + 7'h01;
						if (rx_out) begin
							if (rx_drop) begin
								rx_ones_reg <= 3'h0;
							end else begin
								rx_asm_reg <= rx_asm_n;
								rx_asm_cnt_reg <= rx_asm_cnt_reg + 3'h1;
								if (!rx_win_reg[0]) begin
									rx_ones_reg <= 3'h0;
								end else if (rx_ones_reg != 3'h7) begin
									rx_ones_reg <= rx_ones_reg + 3'h1;
								end
							end
						end else begin
							rx_win_cnt_reg <= rx_win_cnt_reg + 4'h1;
						end
						// Bit leaving the window still lands before the flag restarts
						if (rx_is_flag) begin
							rx_win_cnt_reg <= 4'h0;
							rx_ones_reg <= 3'h0;
							rx_asm_cnt_reg <= 3'h0;
						end
						if (rx_last) begin
							rx_state_reg <= hfa_pkg::HFA_IDLE;
						end
					end
				end
				default: begin
					rx_state_reg <= hfa_pkg::HFA_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receive FIFO
	// ----------------------------------------------------------------
	assign rx_pop = rd_rx_data && (rx_level_reg != 5'h00);

	always_ff @(posedge clk) begin
		if (frst) begin
			rx_head_reg <= 5'h00;
			rx_tail_reg <= 5'h00;
			rx_level_reg <= 5'h00;
		end else begin
			if (rx_push) begin
				rx_fifo_mem[rx_tail_reg] <= rx_asm_n;
				rx_tail_reg <= hfa_wrap(rx_tail_reg);
			end
			if (rx_pop) begin
				rx_head_reg <= hfa_wrap(rx_head_reg);
			end
			if (rx_push && !rx_pop) begin
				rx_level_reg <= rx_level_reg + 5'h01;
			end else if (rx_pop && !rx_push) begin
				rx_level_reg <= rx_level_reg - 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit FIFO
	// ----------------------------------------------------------------
	assign tx_pop = tx_step && tx_load && (tx_level_reg != 5'h00);

	always_ff @(posedge clk) begin
		if (frst) begin
			tx_head_reg <= 5'h00;
			tx_tail_reg <= 5'h00;
			tx_level_reg <= 5'h00;
		end else begin
			if (wr_tx_data && tx_level_reg != `HFA_FIFO_FULL) begin
				tx_fifo_mem[tx_tail_reg] <= wdata;
				tx_tail_reg <= hfa_wrap(tx_tail_reg);
			end
			if (tx_pop) begin
				tx_head_reg <= hfa_wrap(tx_head_reg);
			end
			if (wr_tx_data && tx_level_reg != `HFA_FIFO_FULL && !tx_pop) begin
				tx_level_reg <= tx_level_reg + 5'h01;
			end else if (tx_pop && !(wr_tx_data && tx_level_reg != `HFA_FIFO_FULL)) begin
				tx_level_reg <= tx_level_reg - 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit framer
	// ----------------------------------------------------------------
	always_comb begin
		tx_step = (tx_state_reg == hfa_pkg::HFA_RUN);
		tx_load = (tx_cur_cnt_reg == 4'h0);
		tx_stuff = (tx_ones_reg == `HFA_STUFF_RUN);
		tx_bit = tx_stuff ? 1'b0 : tx_cur_reg[0];
		tx_last = tx_step && !tx_load && ((tx_idx_reg + 7'h01 == tx_bit_count_reg[6:0]
			&& !tx_bit_count_reg[7]) || tx_idx_reg == `HFA_BUF_LAST_BIT);
		tx_flag_sent = tx_step && !tx_load && tx_cur_flag_reg && (tx_cur_cnt_reg == 4'h1);
	end

	always_ff @(posedge clk) begin
		if (frst) begin
			tx_state_reg <= hfa_pkg::HFA_IDLE;
			tx_idx_reg <= 7'h00;
			tx_cur_reg <= 8'h00;
			tx_cur_cnt_reg <= 4'h0;
			tx_cur_flag_reg <= 1'b0;
			tx_ones_reg <= 3'h0;
		end else if (wr_tx_bits) begin
			tx_idx_reg <= 7'h00;
			tx_state_reg <= (wdata != 8'h00) ? hfa_pkg::HFA_RUN : hfa_pkg::HFA_IDLE;
		end else begin
			case (tx_state_reg)
				hfa_pkg::HFA_IDLE: begin
					tx_idx_reg <= 7'h00;
				end
				hfa_pkg::HFA_RUN: begin
					if (tx_load) begin
						tx_cur_cnt_reg <= 4'h8;
						if (tx_level_reg != 5'h00) begin
							tx_cur_reg <= tx_fifo_mem[tx_head_reg];
							tx_cur_flag_reg <= 1'b0;
						end else begin
							tx_cur_reg <= `HFA_FLAG;
							tx_cur_flag_reg <= 1'b1;
						end
					end else begin
						tx_buf_mem[tx_idx_reg[6:3]][tx_idx_reg[2:0]] <= tx_bit;
						tx_idx_reg <= tx_idx_reg + 7'h01;
						if (tx_stuff || tx_cur_flag_reg || !tx_bit) begin
							tx_ones_reg <= 3'h0;
						end else begin
							tx_ones_reg <= tx_ones_reg + 3'h1;
						end
						if (!tx_stuff) begin
							tx_cur_reg <= {1'b0, tx_cur_reg[7:1]};
							tx_cur_cnt_reg <= tx_cur_cnt_reg - 4'h1;
						end
						if (tx_last) begin
							tx_state_reg <= hfa_pkg::HFA_IDLE;
						end
					end
				end
				default: begin
					tx_state_reg <= hfa_pkg::HFA_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Transmit flags and buffer read pointer
	// ----------------------------------------------------------------
	assign tx_thr = thr_sel_reg ? `HFA_THR_HIGH : `HFA_THR_LOW;

	always_ff @(posedge clk) begin
		if (frst) begin
			tx_done_reg <= 1'b0;
			drained_reg <= 1'b0;
			tx_rd_ptr_reg <= 4'h0;
		end else begin
			if (wr_tx_bits) begin
				tx_done_reg <= (wdata == 8'h00);
				tx_rd_ptr_reg <= 4'h0;
			end else begin
				if (tx_last) begin
					tx_done_reg <= 1'b1;
				end
				if (rd_tx_data) begin
					tx_rd_ptr_reg <= tx_rd_ptr_reg + 4'h1;
				end
			end
			if (tx_level_reg >= tx_thr) begin
				drained_reg <= 1'b1;
			end else if (tx_flag_sent && tx_level_reg == 5'h00) begin
				drained_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// CRC helper and read data
	// ----------------------------------------------------------------
	hfa_crc u_crc (
		.clk(clk),
		.rst_n(rst_n),
		.in_wr(wr && hfa_hit(addr, `HFA_A_CRC_DATA)),
		.in_data(wdata),
		.out_rd(rd && hfa_hit(addr, `HFA_A_CRC_DATA)),
		.swrst(wr && hfa_hit(addr, `HFA_A_CRC_STAT) && wdata[`HFA_CRC_SWRST]),
		.out_data(crc_out),
		.status(crc_status),
		.crc_low(crc_low),
		.crc_high(crc_high)
	);

	always_comb begin
		ctrl_status = 8'h00;
		ctrl_status[`HFA_CS_DRAINED] = drained_reg;
		ctrl_status[`HFA_CS_RX_GO] = rx_go_reg;
		ctrl_status[`HFA_CS_THR_SEL] = thr_sel_reg;
		ctrl_status[`HFA_CS_LEVEL] = (tx_level_reg < tx_thr);
		ctrl_status[`HFA_CS_TX_DONE] = tx_done_reg;
		ctrl_status[`HFA_CS_RX_EMPTY] = (rx_level_reg == 5'h00);
		ctrl_status[`HFA_CS_RESET] = frm_rst_reg;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else if (rd) begin
			case (addr)
				`HFA_A_RX_DATA: rdata_reg <= rx_pop ? rx_fifo_mem[rx_head_reg] : 8'h00;
				`HFA_A_TX_DATA: rdata_reg <= tx_buf_mem[tx_rd_ptr_reg];
				`HFA_A_CTRL: rdata_reg <= ctrl_status;
				`HFA_A_CRC_DATA: rdata_reg <= crc_out;
				`HFA_A_CRC_STAT: rdata_reg <= crc_status;
				`HFA_A_CRC_LOW: rdata_reg <= crc_low;
				`HFA_A_CRC_HIGH: rdata_reg <= crc_high;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	assign rdata = rdata_reg;

endmodule

/* File: core/hfa_cfg.svh */
// Constants of the HDLC framing and CRC assist block.
// Assumes a byte-wide register port with 16-bit controller addresses.
`ifndef HFA_CFG_SVH
`define HFA_CFG_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define HFA_A_RX_BIT_COUNT 16'hdc00
`define HFA_A_RX_DATA 16'hdc01
`define HFA_A_TX_BIT_COUNT 16'hdc02
`define HFA_A_TX_DATA 16'hdc03
`define HFA_A_CTRL 16'hdc04
`define HFA_A_CRC_DATA 16'hdc08
`define HFA_A_CRC_STAT 16'hdc09
`define HFA_A_CRC_LOW 16'hdc0a
`define HFA_A_CRC_HIGH 16'hdc0b

// ----------------------------------------------------------------
// Framer control and status fields
// ----------------------------------------------------------------
`define HFA_CS_DRAINED 0
`define HFA_CS_RX_GO 1
`define HFA_CS_THR_SEL 2
`define HFA_CS_LEVEL 3
`define HFA_CS_TX_DONE 4
`define HFA_CS_RX_EMPTY 5
`define HFA_CS_RESET 6

// ----------------------------------------------------------------
// CRC helper status fields
// ----------------------------------------------------------------
`define HFA_CRC_READY 0
`define HFA_CRC_END 1
`define HFA_CRC_OK 2
`define HFA_CRC_IN_EMPTY 3
`define HFA_CRC_SWRST 7

// ----------------------------------------------------------------
// Sizes, patterns and reset values
// ----------------------------------------------------------------
`define HFA_FLAG 8'h7e
`define HFA_FIFO_LAST 5'h14
`define HFA_FIFO_FULL 5'h15
`define HFA_THR_LOW 5'h0b
`define HFA_THR_HIGH 5'h10
`define HFA_BUF_LAST_BIT 7'h7f
`define HFA_STUFF_RUN 3'h5
`define HFA_CRC_INIT 16'hffff
`define HFA_CRC_POLY 16'h8408
`define HFA_CRC_GOOD 16'hf0b8

`endif

/* File: core/hfa_pkg.sv */
// Types of the HDLC framing and CRC assist block.
// Assumes hfa_cfg.svh carries every numeric constant except the state encodings below.
package hfa_pkg;

	// ----------------------------------------------------------------
	// Bit engine states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HFA_IDLE = 2'b01,
		HFA_RUN = 2'b10
	} hfa_state_e;

endpackage

/* File: core/hfa_crc.sv */
// CRC helper: input buffer, output buffer, flags and FCS result.
// Assumes the parent decodes addresses into one-cycle strobes.
`timescale 1ns/100ps
`include "hfa_cfg.svh"

module hfa_crc (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_wr,
	input wire logic [7:0] in_data,
	input wire logic out_rd,
	input wire logic swrst,
	output logic [7:0] out_data,
	output logic [7:0] status,
	output logic [7:0] crc_low,
	output logic [7:0] crc_high
);
	logic [7:0] in_buf_reg;
	logic in_full_reg;
	logic [7:0] out_buf_reg;
	logic ready_reg;
	logic end_reg;
	logic ok_reg;
	logic started_reg;
	logic [15:0] crc_reg;
	logic [15:0] crc_next;
	logic [15:0] result_reg;
	logic is_flag;
	logic srst;

	function automatic logic [15:0] hfa_crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `HFA_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	assign srst = !rst_n || swrst;
	assign is_flag = (in_buf_reg == `HFA_FLAG);
	assign crc_next = hfa_crc_byte(crc_reg, in_buf_reg);

	// ----------------------------------------------------------------
	// Input buffer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			in_buf_reg <= 8'h00;
			in_full_reg <= 1'b0;
		end else if (in_wr) begin
			in_buf_reg <= in_data;
			in_full_reg <= 1'b1;
		end else begin
			in_full_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// CRC engine, one byte per cycle
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			crc_reg <= `HFA_CRC_INIT;
			result_reg <= 16'h0000;
			started_reg <= 1'b0;
			end_reg <= 1'b0;
			ok_reg <= 1'b0;
			out_buf_reg <= 8'h00;
		end else if (in_full_reg) begin
			if (is_flag) begin
				if (started_reg) begin
					end_reg <= 1'b1;
					ok_reg <= (crc_reg == `HFA_CRC_GOOD);
				end
				crc_reg <= `HFA_CRC_INIT;
				started_reg <= 1'b0;
			end else begin
				crc_reg <= crc_next;
				result_reg <= ~crc_next;
				out_buf_reg <= in_buf_reg;
				started_reg <= 1'b1;
			end
		end
	end

	// Set wins over the clear by read
	always_ff @(posedge clk) begin
		if (srst) begin
			ready_reg <= 1'b0;
		end else if (in_full_reg && !is_flag) begin
			ready_reg <= 1'b1;
		end else if (out_rd) begin
			ready_reg <= 1'b0;
		end
	end

	assign out_data = out_buf_reg;
	assign crc_low = result_reg[7:0];
	assign crc_high = result_reg[15:8];
	always_comb begin
		status = 8'h00;
		status[`HFA_CRC_READY] = ready_reg;
		status[`HFA_CRC_END] = end_reg;
		status[`HFA_CRC_OK] = ok_reg;
		status[`HFA_CRC_IN_EMPTY] = !in_full_reg;
	end

endmodule

/* File: test/hfa_top_monitor.sv */
// Checker on the register port of the framing and CRC assist block.
// Assumes it is bound to hfa_top and sees only its ports.
`timescale 1ns/100ps
`include "hfa_cfg.svh"

module hfa_top_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata
);
	// ----
	// Decodes and shadow of control bits 2 and 6
	// ----
	logic [7:0] ctl_reg;
	logic known, rd_ctl, rd_st, rd_dat, wr_dat, wr_cnt;
	assign known = addr inside {[16'hdc00:16'hdc04], [16'hdc08:16'hdc0b]};
	assign rd_ctl = rd && addr == `HFA_A_CTRL;
	assign rd_st = rd && addr == `HFA_A_CRC_STAT;
	assign rd_dat = rd && addr == `HFA_A_CRC_DATA;
	assign wr_dat = wr && addr == `HFA_A_CRC_DATA;
	assign wr_cnt = wr && addr == `HFA_A_TX_BIT_COUNT;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl_reg <= 8'h00;
		end else if (wr && addr == `HFA_A_CTRL) begin
			ctl_reg <= wdata & 8'h44;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----
	// Assertions
	// ----
	AST_UNMAPPED_READ: assert property (rd && !known |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RDATA_HOLDS: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without a read");
	AST_CTRL_READBACK: assert property (rd_ctl |=> (rdata & 8'hc4) == ctl_reg)
		else $error("control bits read back wrong");
	AST_CRC_HIGH_ZERO: assert property (rd_st |=> rdata[7:4] == 4'h0)
		else $error("helper status upper bits not zero");
	AST_READY_CLEARS: assert property (!wr_dat ##1 rd_dat ##1 rd_st |=> !rdata[0])
		else $error("data ready not cleared by read");
	AST_IN_EMPTY_CLEARS: assert property (wr_dat ##1 rd_st |=> !rdata[3])
		else $error("input empty not cleared by write");
	AST_SWRST_IDLE: assert property (wr && addr == `HFA_A_CRC_STAT && wdata[7] ##1 rd_st
		|=> rdata[3:0] == 4'h8) else $error("helper reset left flags set");
	AST_FRAME_RESET_IDLE: assert property (ctl_reg[6] && $past(ctl_reg[6]) && rd_ctl
		|=> (rdata & 8'h3b) == 8'h28) else $error("framing reset left flags set");
	AST_ZERO_COUNT_DONE: assert property (wr_cnt && wdata == 8'h00 && !ctl_reg[6]
		##1 !wr_cnt ##1 rd_ctl |=> rdata[4]) else $error("zero bit count not done");
	cover property (rd_st ##1 rdata[1]);
	cover property (rd_ctl ##1 rdata[4]);
	cover property (rd && addr == `HFA_A_RX_DATA ##1 rdata != 8'h00);
endmodule

bind hfa_top hfa_top_monitor i_hfa_top_monitor (.clk(clk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

/* File: test/hfa_top_test.sv */
// Self-checking bench of the framing and CRC assist block.
// Assumes hfa_top with one-cycle strobes and read data one cycle later.
`timescale 1ns/100ps
`include "hfa_cfg.svh"

module hfa_top_test;
	localparam logic [7:0] FLAG = `HFA_FLAG;
	logic clk, rst_n, wr, rd;
	logic [15:0] addr, crc;
	logic [7:0] wdata, rdata, v, e;
	logic [7:0] q[$];
	bit bq[$];
	int bad_count, check_count, run;

	hfa_top i_hfa_top (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----
	// Bus tasks and model helpers
	// ----
	task end_of_test;
		if (bad_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task put(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask
	task get(input logic [15:0] a, output logic [7:0] d);
		put(1'b0, 1'b1, a, 8'h00);
		put(1'b0, 1'b0, a, 8'h00);
		d = rdata;
	endtask
	task poll(input int n, input logic level);
		for (int i = 0; i < 200; i++) begin
			get(`HFA_A_CTRL, v);
			if (v[n] === level) return;
		end
		bad_count++;
		end_of_test();
	endtask
	task crc_add(input logic [7:0] b);
		crc = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			crc = crc[0] ? ((crc >> 1) ^ `HFA_CRC_POLY) : (crc >> 1);
		end
	endtask
	task frame_reset(input logic s);
		put(1'b1, 1'b0, `HFA_A_CTRL, {5'h08, s, 2'h0});
		put(1'b1, 1'b0, `HFA_A_CTRL, {5'h00, s, 2'h0});
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
		v = $urandom(66);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		get(`HFA_A_CTRL, v);
		check("ctrl_reset", v, 8'h28);
		get(`HFA_A_CRC_STAT, v);
		check("crc_reset", v, 8'h08);
		put(1'b1, 1'b0, 16'hdc05, 8'hff);
		get(16'hdc05, v);
		check("unmapped", v, 8'h00);
		put(1'b1, 1'b0, `HFA_A_CTRL, 8'h40);
		put(1'b0, 1'b0, `HFA_A_CTRL, 8'h00);
		get(`HFA_A_CTRL, v);
		check("ctrl_held", v, 8'h68);
		for (int s = 0; s < 2; s++) begin
			for (int k = 10 + 5 * s; k < 12 + 5 * s; k++) begin
				frame_reset(s[0]);
				repeat (k) put(1'b1, 1'b0, `HFA_A_TX_DATA, 8'($urandom));
				put(1'b0, 1'b0, `HFA_A_CTRL, 8'h00);
				get(`HFA_A_CTRL, v);
				check("threshold", v, {4'h2, k < 11 + 5 * s, s[0], 1'b0, k >= 11 + 5 * s});
			end
		end
		frame_reset(1'b0);
		put(1'b1, 1'b0, `HFA_A_TX_BIT_COUNT, 8'h00);
		put(1'b0, 1'b0, `HFA_A_CTRL, 8'h00);
		get(`HFA_A_CTRL, v);
		check("tx_zero", {7'h00, v[4]}, 8'h01);
		q = {8'hff, 8'($urandom)};
		run = 0;
		foreach (q[j]) begin
			put(1'b1, 1'b0, `HFA_A_TX_DATA, q[j]);
			for (int i = 0; i < 8; i++) begin
				bq.push_back(q[j][i]);
				run = q[j][i] ? run + 1 : 0;
				if (run == 5) begin
					bq.push_back(1'b0);
					run = 0;
				end
			end
		end
		while (bq.size() < 40) for (int i = 0; i < 8; i++) bq.push_back(FLAG[i]);
		put(1'b1, 1'b0, `HFA_A_TX_BIT_COUNT, 8'h28);
		poll(4, 1'b1);
		for (int j = 0; j < 5; j++) begin
			for (int i = 0; i < 8; i++) e[i] = bq[8 * j + i];
			get(`HFA_A_TX_DATA, v);
			check("tx_buffer", v, e);
		end
		frame_reset(1'b0);
		q = {FLAG, 8'($urandom) & 8'h77, 8'($urandom) & 8'h77, FLAG, FLAG};
		foreach (q[j]) put(1'b1, 1'b0, `HFA_A_RX_DATA, q[j]);
		put(1'b1, 1'b0, `HFA_A_RX_BIT_COUNT, 8'h28);
		put(1'b1, 1'b0, `HFA_A_CTRL, 8'h02);
		poll(1, 1'b0);
		for (int j = 1; j < 4; j++) begin
			get(`HFA_A_RX_DATA, v);
			check("rx_fifo", v, j < 3 ? q[j] : 8'h00);
		end
		get(`HFA_A_CTRL, v);
		check("rx_done", v, 8'h28);
		crc = `HFA_CRC_INIT;
		for (int j = 0; j < 4; j++) begin
			e = 8'($urandom);
			if (e == FLAG) e = 8'h00;
			crc_add(e);
			put(1'b1, 1'b0, `HFA_A_CRC_DATA, e);
			get(`HFA_A_CRC_STAT, v);
			check("in_empty", v & 8'h08, 8'h00);
			put(1'b0, 1'b1, `HFA_A_CRC_DATA, 8'h00);
			addr <= `HFA_A_CRC_STAT;
			@(negedge clk);
			check("crc_out", rdata, e);
			@(posedge clk);
			put(1'b0, 1'b0, `HFA_A_CRC_STAT, 8'h00);
			check("ready_clear", rdata & 8'h01, 8'h00);
			get(`HFA_A_CRC_LOW, v);
			check("crc_low", v, ~crc[7:0]);
			get(`HFA_A_CRC_HIGH, v);
			check("crc_high", v, ~crc[15:8]);
		end
		for (int p = 0; p < 2; p++) begin
			if (p == 0) begin
				q = {~crc[7:0], ~crc[15:8], FLAG};
			end else begin
				q = {e, FLAG};
			end
			foreach (q[j]) begin
				put(1'b1, 1'b0, `HFA_A_CRC_DATA, q[j]);
				put(1'b0, 1'b0, `HFA_A_CRC_DATA, 8'h00);
				if (q[j] != FLAG) crc_add(q[j]);
			end
			get(`HFA_A_CRC_STAT, v);
			check("frame_end", v, {5'h01, crc == `HFA_CRC_GOOD, 2'h3});
			crc = `HFA_CRC_INIT;
		end
		put(1'b1, 1'b0, `HFA_A_CRC_STAT, 8'h80);
		get(`HFA_A_CRC_STAT, v);
		check("crc_swrst", v, 8'h08);
		end_of_test();
	end
endmodule
